/* gocal_regs.svh */
// constants for the converter gain and offset correction core
`ifndef GOCAL_REGS_SVH
`define GOCAL_REGS_SVH

// coefficient word layout in non-volatile storage
`define GOCAL_WORD_W 33
`define GOCAL_ONEPT_BIT 32
`define GOCAL_GAIN_MSB 31
`define GOCAL_GAIN_LSB 16
`define GOCAL_OFS_MSB 15
`define GOCAL_OFS_LSB 0

// fixed point: gain unsigned with 14 fraction bits, offset signed in result lsbs
`define GOCAL_GAIN_FRAC 14
`define GOCAL_GAIN_ONE 16'h4000
`define GOCAL_OFS_ZERO 16'h0000

// storage map: one word per channel, then the temperature offset word
`define GOCAL_NUM_CHAN 32
`define GOCAL_TEMP_IDX 6'h20
`define GOCAL_NUM_WORDS 6'h21
`define GOCAL_NVM_BASE 16'h0000

`endif

/* gocal_pkg.sv */
// types shared by the converter gain and offset correction core
package gocal_pkg;

    typedef enum logic [1:0] {
        GOCAL_SRC_PRESCALED = 2'h0,
        GOCAL_SRC_DIRECT = 2'h1,
        GOCAL_SRC_TEMP = 2'h2,
        GOCAL_SRC_CURRENT = 2'h3
    } gocal_src_t;

    typedef enum logic [1:0] {
        GOCAL_ST_LOAD_REQ = 2'b00,
        GOCAL_ST_LOAD_WAIT = 2'b01,
        GOCAL_ST_RUN = 2'b11
    } gocal_state_t;

    typedef struct packed {
        logic [4:0] chan;
        gocal_src_t src;
        logic sat;
        logic [11:0] data;
    } gocal_raw_t;

    typedef struct packed {
        logic [4:0] chan;
        gocal_src_t src;
        logic [11:0] data;
    } gocal_corr_t;

endpackage : gocal_pkg

/* gocal_calibration_core.sv */
// converter result correction core with power-up coefficient loader
`timescale 1ns/1ps
`default_nettype none
`include "gocal_regs.svh"

module gocal_calibration_core #(
    parameter int NUM_CHAN = `GOCAL_NUM_CHAN,
    parameter logic [15:0] NVM_BASE = `GOCAL_NVM_BASE
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic bypassOnSat,
    output logic nvmRdReq,
    output logic [15:0] nvmAddr,
    input wire logic nvmRdValid,
    input wire logic [`GOCAL_WORD_W-1:0] nvmRdData,
    output logic calReady,
    input wire logic rawValid,
    input wire gocal_pkg::gocal_raw_t rawRes,
    output logic corrValid,
    output var gocal_pkg::gocal_corr_t corrRes
);
    import gocal_pkg::*;

    localparam int NWORDS = NUM_CHAN + 1;

    // loader state
    gocal_state_t state_ff;
    gocal_state_t nxt_state;
    logic [5:0] loadIdx_ff;
    logic [5:0] nxt_loadIdx;
    logic rdReq_ff;
    logic nxt_rdReq;
    logic ready_ff;
    logic nxt_ready;

    // local coefficient memory, last word holds the temperature offset
    logic [`GOCAL_WORD_W-1:0] coefMem_ff [NWORDS];
    logic [`GOCAL_WORD_W-1:0] nxt_coefMem [NWORDS];

    // stage one: result with its looked-up coefficients
    logic s1Valid_ff;
    logic nxt_s1Valid;
    gocal_raw_t s1Raw_ff;
    gocal_raw_t nxt_s1Raw;
    logic [`GOCAL_WORD_W-1:0] s1Coef_ff;
    logic [`GOCAL_WORD_W-1:0] nxt_s1Coef;
    logic [15:0] s1TempOfs_ff;
    logic [15:0] nxt_s1TempOfs;

    // stage two: output registers
    logic outValid_ff;
    logic nxt_outValid;
    gocal_corr_t outRes_ff;
    gocal_corr_t nxt_outRes;

    logic [27:0] product;
    logic signed [18:0] sum;
    logic [11:0] clamped;

    // fields of the stage-one coefficient word, widened for signed arithmetic
    logic s1OnePt;
    logic [15:0] s1Gain;
    logic signed [18:0] rawExt;
    logic signed [18:0] ofsExt;
    logic signed [18:0] tempExt;
    logic signed [18:0] scaledExt;

    // loader: one word per request, channels first, temperature word last
    always_comb begin
        nxt_state = state_ff;
        nxt_loadIdx = loadIdx_ff;
        nxt_rdReq = 1'b0;
        nxt_ready = ready_ff;
        nxt_coefMem = coefMem_ff;
        case (state_ff)
            GOCAL_ST_LOAD_REQ: begin
                // one read outstanding at a time keeps the storage port simple
                nxt_rdReq = 1'b1;
                nxt_state = GOCAL_ST_LOAD_WAIT;
            end
            GOCAL_ST_LOAD_WAIT: begin
                // no timeout: a silent store keeps calReady low for good
                if (nvmRdValid) begin
                    nxt_coefMem[loadIdx_ff[5:0]] = nvmRdData;
                    if (loadIdx_ff == 6'(NWORDS - 1)) begin
                        nxt_state = GOCAL_ST_RUN;
                        nxt_ready = 1'b1;
                    end else begin
                        nxt_loadIdx = loadIdx_ff + 6'h01;
                        nxt_state = GOCAL_ST_LOAD_REQ;
                    end
                end
            end
            GOCAL_ST_RUN: begin
                // coefficients stay fixed until the next reset
                nxt_state = GOCAL_ST_RUN;
            end
            default: begin
                // unused code: go back to requesting at the current load index rather than hang
                nxt_state = GOCAL_ST_LOAD_REQ;
            end
        endcase
    end

    // stage one: latch the result and the coefficients of its channel
    always_comb begin
        // results offered before loading is done are dropped
        nxt_s1Valid = rawValid && ready_ff;
        nxt_s1Raw = rawRes;
        nxt_s1Coef = coefMem_ff[{1'b0, rawRes.chan}];
        // temperature offset does not depend on the channel
        nxt_s1TempOfs = coefMem_ff[`GOCAL_TEMP_IDX][`GOCAL_OFS_MSB:`GOCAL_OFS_LSB];
    end

    // stage two: correct, clamp and register the result
    always_comb begin
        s1OnePt = s1Coef_ff[`GOCAL_ONEPT_BIT];
        s1Gain = s1Coef_ff[`GOCAL_GAIN_MSB:`GOCAL_GAIN_LSB];
        product = 28'(s1Raw_ff.data) * 28'(s1Gain);
        // raw results are unsigned and offsets signed, so widen both before mixing
        rawExt = signed'({7'h00, s1Raw_ff.data});
        ofsExt = 19'(signed'(s1Coef_ff[`GOCAL_OFS_MSB:`GOCAL_OFS_LSB]));
        tempExt = 19'(signed'(s1TempOfs_ff));
        // gain stays below four, so the integer part of the product fits 14 bits
        scaledExt = signed'({5'h00, product[27:`GOCAL_GAIN_FRAC]});

        sum = 19'sd0;
        if (s1Raw_ff.src == GOCAL_SRC_TEMP) begin
            sum = rawExt - tempExt;
        end else if (s1OnePt) begin
            sum = rawExt + ofsExt;
        end else begin
            sum = scaledExt + ofsExt;
        end

        // saturate instead of wrapping so a bad coefficient cannot flip full scale to zero
        if (sum < 19'sd0) begin
            clamped = 12'h000;
        end else if (sum > 19'sd4095) begin
            clamped = 12'hfff;
        end else begin
            clamped = sum[11:0];
        end

        nxt_outValid = s1Valid_ff;
        nxt_outRes.chan = s1Raw_ff.chan;
        nxt_outRes.src = s1Raw_ff.src;
        if (s1Raw_ff.src == GOCAL_SRC_DIRECT || s1Raw_ff.src == GOCAL_SRC_CURRENT) begin
            nxt_outRes.data = s1Raw_ff.data;
        end else if (s1Raw_ff.sat && bypassOnSat) begin
            // a saturated reading is not exact, so it may be kept as read
            nxt_outRes.data = s1Raw_ff.data;
        end else begin
            nxt_outRes.data = clamped;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= GOCAL_ST_LOAD_REQ;
            loadIdx_ff <= 6'h00;
            rdReq_ff <= 1'b0;
            ready_ff <= 1'b0;
            // unity gain and zero offset until the loader fills the memory
            for (int i = 0; i < NWORDS; i++) begin
                coefMem_ff[i] <= {1'b0, `GOCAL_GAIN_ONE, `GOCAL_OFS_ZERO};
            end
            // pipeline starts empty so nothing leaves before a result is taken
            s1Valid_ff <= 1'b0;
            s1Raw_ff <= '0;
            s1Coef_ff <= '0;
            s1TempOfs_ff <= 16'h0000;
            outValid_ff <= 1'b0;
            outRes_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            loadIdx_ff <= nxt_loadIdx;
            rdReq_ff <= nxt_rdReq;
            ready_ff <= nxt_ready;
            coefMem_ff <= nxt_coefMem;

            s1Valid_ff <= nxt_s1Valid;
            s1Raw_ff <= nxt_s1Raw;
            s1Coef_ff <= nxt_s1Coef;
            s1TempOfs_ff <= nxt_s1TempOfs;
            outValid_ff <= nxt_outValid;
            outRes_ff <= nxt_outRes;
        end
    end

    // address follows the index about to be requested, so it is in place with the pulse
    logic [15:0] addr_ff;
    logic [15:0] nxt_addr;

    always_comb begin
        nxt_addr = NVM_BASE + 16'(nxt_loadIdx);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_ff <= 16'h0000;
        end else begin
            addr_ff <= nxt_addr;
        end
    end

    assign nvmRdReq = rdReq_ff;
    assign nvmAddr = addr_ff;
    assign calReady = ready_ff;
    assign corrValid = outValid_ff;
    assign corrRes = outRes_ff;

endmodule : gocal_calibration_core
`default_nettype wire

/* gocal_core_sva.sv */
// port assertions for the correction core
`timescale 1ns/1ps
`default_nettype none
module gocal_core_sva (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic bypassOnSat,
    input wire logic nvmRdReq,
    input wire logic calReady,
    input wire logic rawValid,
    input wire gocal_pkg::gocal_raw_t rawRes,
    input wire logic corrValid,
    input wire gocal_pkg::gocal_corr_t corrRes
);
    import gocal_pkg::*;
    wire logic tk = rawValid && calReady;
    // direct and current always pass, others only when bypassing saturation
    wire logic thru = rawRes.src[0] || (bypassOnSat && rawRes.sat);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    chk_out_latency: assert property (tk |-> ##2 corrValid) else $error("late");
    chk_no_extra: assert property (corrValid |-> $past(tk, 2)) else $error("extra");
    chk_chan_sel: assert property (tk |-> ##2 corrRes.chan == $past(rawRes.chan, 2))
        else $error("chan");
    chk_src_kept: assert property (tk |-> ##2 corrRes.src == $past(rawRes.src, 2))
        else $error("src");
    chk_pass_thru: assert property (tk && thru |-> ##2 corrRes.data == $past(rawRes.data, 2))
        else $error("altered");
    chk_idle_drop: assert property (!calReady |-> ##2 !corrValid) else $error("early");
    chk_ready_holds: assert property (calReady |=> calReady) else $error("ready");
    chk_req_single: assert property (nvmRdReq |=> !nvmRdReq) else $error("req");
    cover property (tk && rawRes.src == GOCAL_SRC_TEMP);
    cover property (tk && thru ##1 tk);
    cover property ($rose(calReady));
endmodule : gocal_core_sva
bind gocal_calibration_core gocal_core_sva gocal_core_sva_inst (.*);
`default_nettype wire

/* gocal_nvm_model.sv */
// coefficient storage answering reads after a set latency
`timescale 1ns/1ps
`default_nettype none
module gocal_nvm_model #(parameter int LAT = 1) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic nvmRdReq,
    input wire logic [15:0] nvmAddr,
    input wire logic [32:0] words [0:32],
    output logic nvmRdValid,
    output logic [32:0] nvmRdData
);
    int cnt_ff;
    logic [15:0] addr_ff;
    // data toggles outside a reply so a stale sample shows up
    always @(posedge ref_clk or negedge arst_n) begin
        nvmRdValid <= arst_n && cnt_ff == 1;
        nvmRdData <= !arst_n ? '0 : cnt_ff == 1 ? words[addr_ff[5:0]] : ~nvmRdData;
        addr_ff <= nvmRdReq ? nvmAddr : addr_ff;
        cnt_ff <= !arst_n ? 0 : nvmRdReq ? LAT : cnt_ff - int'(cnt_ff > 0);
    end
endmodule : gocal_nvm_model
`default_nettype wire

/* adc_gain_offset_calibration_tb.sv */
// self-checking bench for the correction core
`timescale 1ns/1ps
`default_nettype none
module adc_gain_offset_calibration_tb;
    import gocal_pkg::*;
    logic ref_clk = 0, arst_n = 0, bypassOnSat = 0, rawValid = 0;
    logic nvmRdReq, nvmRdValid, calReady, corrValid;
    logic [15:0] nvmAddr;
    logic [32:0] nvmRdData, words [0:32];
    gocal_raw_t rawRes = '0, rows [128];
    gocal_corr_t corrRes, expQ [$];
    int failures = 0, num_checks = 0, cycles = 0, idx = 0;
    gocal_calibration_core gocal_calibration_core_inst (.*);
    gocal_nvm_model #(.LAT(3)) gocal_nvm_model_inst (.*);
    initial forever #5 ref_clk = ~ref_clk;
    task automatic check(input logic [18:0] got, input logic [18:0] exp);
        num_checks++;
        if (got !== exp) failures++;
        if (got !== exp) $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    endtask : check
    task automatic conclude();
        failures += cycles / 3000;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    function automatic gocal_corr_t fix(gocal_raw_t r, logic b);
        logic [32:0] w = words[r.chan];
        int v = r.data;
        if (r.src == GOCAL_SRC_TEMP && !(b && r.sat)) v -= int'($signed(words[32][15:0]));
        if (r.src == GOCAL_SRC_PRESCALED && !(b && r.sat))
            v = (w[32] ? v : v * int'(w[31:16]) >>> 14) + int'($signed(w[15:0]));
        return '{r.chan, r.src, 12'(v < 0 ? 0 : v > 4095 ? 4095 : v)};
    endfunction : fix
    task automatic load();
        arst_n = 1'b1;
        while (calReady !== 1'b1) @(posedge ref_clk) #1;
        check(19'(idx), 19'h21);
        $display("load done");
    endtask : load
    always @(posedge ref_clk) begin
        if (++cycles == 3000) conclude();
        if (corrValid) check(corrRes, expQ.size() ? expQ.pop_front() : 19'hx);
        if (nvmRdReq) check(19'(nvmAddr), 19'(idx));
        idx += int'(nvmRdReq);
    end
    initial begin
        for (int i = 0; i < 33; i++)
            words[i] = {i[0], 16'h2000 + 16'(i * 16'h180), 16'(i * 7 - 100)};
        foreach (rows[k])
            rows[k] = '{5'(k), gocal_src_t'(k / 32), k[1], 12'(k == 31 ? 4095 : k * 397)};
        // offered while reset is held and while loading, so every one must be dropped
        rawValid = 1'b1;
        repeat (4) @(posedge ref_clk) #1;
        load();
        for (int n = 0; n < 256; n++) begin
            bypassOnSat = n[7];
            rawRes = rows[n % 128];
            expQ.push_back(fix(rawRes, bypassOnSat));
            @(posedge ref_clk) #1;
        end
        rawValid = 1'b0;
        repeat (4) @(posedge ref_clk) #1;
        $display("stream done");
        arst_n = 1'b0;
        #1 check(19'({corrValid, calReady, nvmRdReq}), 19'h0);
        idx = 0;
        repeat (2) @(posedge ref_clk) #1;
        load();
        conclude();
    end
endmodule : adc_gain_offset_calibration_tb
`default_nettype wire
